// *** logic/pil_params.svh ***
// Purpose: Constants of the priority interrupt level block
// Assumes: Included by the package and by every design file that needs a figure
// Notes:   Level numbers are octal in the machine; they are kept here as plain values
`ifndef PIL_PARAMS_SVH
`define PIL_PARAMS_SVH

// Level populations
`define PIL_N_HW         40
`define PIL_N_SP         896
`define PIL_N_LVL        936
`define PIL_N_GRP        56
`define PIL_GRP_W        16
`define PIL_IDX_W        10
`define PIL_LVL_W        10

// Level numbering
`define PIL_HW_BASE      10'h018
`define PIL_SP_BASE      10'h080
`define PIL_IDX_YB_EOW   0
`define PIL_IDX_WB_EOW   1
`define PIL_IDX_YB_EOT   2
`define PIL_IDX_WB_EOT   3
`define PIL_IDX_PWR_ON   6
`define PIL_IDX_PWR_OFF  7
`define PIL_N_PWR        2

// Installation options
`define PIL_HW_PAIRS     20'hFFFFF
`define PIL_SP_COUNT     896
`define PIL_ARM_UNIT     1'b1
`define PIL_SINGLE_MASK  {936{1'b0}}
`define PIL_ARM_RST      16'h0000

// Register byte offsets
`define PIL_REG_CTRL     5'h00
`define PIL_REG_GROUP    5'h04
`define PIL_REG_ARM      5'h08
`define PIL_REG_LVLSTAT  5'h0C
`define PIL_REG_STATUS   5'h10

// Field positions
`define PIL_CTRL_EN      0
`define PIL_CTRL_IND     1
`define PIL_ST_REQ       10
`define PIL_ST_ACT_LVL   11
`define PIL_ST_ACT       21
`define PIL_LS_SVC       16

`endif

// *** logic/pil_pkg.sv ***
// Purpose: Types shared by the priority interrupt level block
// Assumes: pil_params.svh holds every figure
// Notes:   Structs carry the sequencer handshake as one bundle
`include "pil_params.svh"

package pil_pkg;

	// Request toward the instruction sequencer
	typedef struct packed {
		logic                    req;
		logic [`PIL_LVL_W-1:0]   level;
	} pil_seq_req_s;

	// Strobes from the instruction sequencer
	typedef struct packed {
		logic ack;
		logic ind_branch;
		logic inst_done;
		logic multi_cycle;
	} pil_seq_cmd_s;

	// Reported state of one level
	typedef enum logic [1:0] {
		PIL_INACTIVE,
		PIL_WAITING,
		PIL_ACTIVE
	} pil_lvl_state_e;

endpackage : pil_pkg

// *** logic/pil_level_cell.sv ***
// Purpose: Pending and in-service flip-flops of one interrupt level
// Assumes: Pulses are synchronous one-cycle strobes
// Notes:   An arriving pulse wins over a clear in the same cycle
`timescale 1ns/1ps

module pil_level_cell (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Controls
	input  wire logic start_clr,
	input  wire logic pulse,
	input  wire logic armed,
	input  wire logic set_svc,
	input  wire logic clr,
	// State
	output logic      level_pending_flop,
	output logic      level_in_service_flop
);

	////////////////////////////////////////////////////////////////
	// Pending: only an armed pulse is caught, a disarmed one is lost
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || start_clr)
			level_pending_flop <= 1'b0;
		else if (pulse && armed)
			level_pending_flop <= 1'b1;
		else if (clr)
			level_pending_flop <= 1'b0;
	end

	// In service: set by acknowledge, dropped by the level clear
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || start_clr)
			level_in_service_flop <= 1'b0;
		else if (set_svc)
			level_in_service_flop <= 1'b1;
		else if (clr)
			level_in_service_flop <= 1'b0;
	end

endmodule : pil_level_cell

// *** logic/pil_prio_enc.sv ***
// Purpose: Finds the lowest set position of a rank-ordered vector
// Assumes: Position 0 is the highest priority
// Notes:   Pure combinational; depth grows with the vector
`timescale 1ns/1ps
`include "pil_params.svh"

module pil_prio_enc (
	// Input
	input  wire logic [`PIL_N_LVL-1:0] vec,
	// Result
	output logic                       found,
	output logic [`PIL_IDX_W-1:0]      rank
);

	// Scan from lowest priority upward so the best one is written last
	always_comb
	begin
		found = 1'b0;
		rank  = '0;
		for (int i = `PIL_N_LVL - 1; i >= 0; i--)
		begin
			if (vec[i])
			begin
				found = 1'b1;
				rank  = i[`PIL_IDX_W-1:0];
			end
		end
	end

endmodule : pil_prio_enc

// *** logic/pil_top.sv ***
// Purpose: Priority interrupt levels with pending, request and in-service state
// Assumes: Sequencer strobes and device pulses are synchronous to clk_sys
// Notes:   Flat index 0..39 is levels 030..077, 40..935 is levels 0200..01777
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pil_params.svh"

module pil_top
	import pil_pkg::*;
(
	// Clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       rstn,
	// Avalon-MM slave
	input  wire logic [4:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic [31:0]                     avs_readdata,
	output logic                            avs_waitrequest,
	// Console
	input  wire logic                       console_start,
	input  wire logic                       enable_switch_held,
	output logic                            interrupt_enabled_ind,
	// Interrupt devices
	input  wire logic [`PIL_N_LVL-1:0]      level_pulse,
	// Instruction sequencer
	input  wire pil_pkg::pil_seq_cmd_s      seq_cmd,
	output pil_pkg::pil_seq_req_s           seq_req
);
	import pil_pkg::*;

	////////////////////////////////////////////////////////////////
	// Helpers

	// Rank position to flat index: power levels lead, then numeric order
	function automatic logic [`PIL_IDX_W-1:0] rank_to_flat(input logic [`PIL_IDX_W-1:0] r);
		if (r < `PIL_IDX_W'(`PIL_N_PWR))
			rank_to_flat = r + `PIL_IDX_W'(`PIL_IDX_PWR_ON);
		else if (r < `PIL_IDX_W'(`PIL_IDX_PWR_ON + `PIL_N_PWR))
			rank_to_flat = r - `PIL_IDX_W'(`PIL_N_PWR);
		else
			rank_to_flat = r;
	endfunction : rank_to_flat

	// Flat index to machine level number
	function automatic logic [`PIL_LVL_W-1:0] flat_to_level(input logic [`PIL_IDX_W-1:0] f);
		if (f < `PIL_IDX_W'(`PIL_N_HW))
			flat_to_level = `PIL_HW_BASE + f;
		else
			flat_to_level = `PIL_SP_BASE + f - `PIL_IDX_W'(`PIL_N_HW);
	endfunction : flat_to_level

	// Levels that ignore the global enable entirely
	function automatic logic is_fixed(input int f);
		is_fixed = (f == `PIL_IDX_PWR_ON) || (f == `PIL_IDX_PWR_OFF);
	endfunction : is_fixed

	////////////////////////////////////////////////////////////////
	// Declarations
	// Installation map of single-instruction levels, indexed by flat level
	localparam logic [`PIL_N_LVL-1:0] SINGLE_LVLS = `PIL_SINGLE_MASK;

	logic                       enable_ff;
	logic [5:0]                 group_ff;
	logic [`PIL_GRP_W-1:0]      arm_ff [`PIL_N_GRP];
	logic                       req_ff;
	logic [`PIL_IDX_W-1:0]      req_idx_ff;
	logic                       single_ff;
	logic [`PIL_IDX_W-1:0]      single_idx_ff;
	logic                       bus_ack_ff;
	logic [31:0]                rdata_ff;

	logic [`PIL_N_LVL-1:0]      present;
	logic [`PIL_N_LVL-1:0]      armed;
	logic [`PIL_N_LVL-1:0]      enabled;
	logic [`PIL_N_LVL-1:0]      pending;
	logic [`PIL_N_LVL-1:0]      in_svc;
	logic [`PIL_N_LVL-1:0]      set_svc;
	logic [`PIL_N_LVL-1:0]      clr;
	logic [`PIL_N_LVL-1:0]      cand_rk;
	logic [`PIL_N_LVL-1:0]      svc_rk;
	logic                       cand_found;
	logic [`PIL_IDX_W-1:0]      cand_rank;
	logic                       act_found;
	logic [`PIL_IDX_W-1:0]      act_rank;
	logic [`PIL_IDX_W-1:0]      act_idx;
	logic                       cand_ok;
	logic                       take_ack;
	logic                       clr_branch;
	logic                       clr_single;
	logic                       bus_wr;
	logic                       bus_rd;
	logic                       grp_valid;
	logic [`PIL_GRP_W-1:0]      grp_pend;
	logic [`PIL_GRP_W-1:0]      grp_svc;

	////////////////////////////////////////////////////////////////
	// Global enable

	// Indicator: the held switch overrides a disable, never an enable
	assign interrupt_enabled_ind = enable_ff | enable_switch_held;

	// Enable flop: software set and clear, console start turns it off
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || console_start)
			enable_ff <= 1'b0;
		else if (bus_wr && avs_address == `PIL_REG_CTRL && avs_byteenable[0])
			enable_ff <= avs_writedata[`PIL_CTRL_EN];
	end

	////////////////////////////////////////////////////////////////
	// Population, arming and enabling of each level
	generate
		for (genvar k = 0; k < `PIL_N_LVL; k++)
		begin : g_gate
			if (k < `PIL_N_HW)
			begin : g_hw
				// Fitted in pairs; the W buffer levels are always there
				localparam logic FIT = 1'((`PIL_HW_PAIRS >> (k / 2)) & 20'h00001);
				assign present[k] = FIT || k == `PIL_IDX_WB_EOW
					|| k == `PIL_IDX_WB_EOT;
				// Hardware levels follow the indicator, power ones do not
				assign armed[k]   = is_fixed(k) ? 1'b1
					: interrupt_enabled_ind;
				assign enabled[k] = is_fixed(k) ? 1'b1
					: interrupt_enabled_ind;
			end
			else
			begin : g_sp
				localparam int J = k - `PIL_N_HW;
				assign present[k] = (J < `PIL_SP_COUNT);
				// Without the arm unit every special level is armed
				assign armed[k]   = `PIL_ARM_UNIT ? arm_ff[J / `PIL_GRP_W][J % `PIL_GRP_W]
					: 1'b1;
				assign enabled[k] = interrupt_enabled_ind;
			end
			// Acknowledge and clear decode for this level
			assign set_svc[k] = take_ack && req_idx_ff == `PIL_IDX_W'(k);
			assign clr[k]     = (clr_branch && act_idx == `PIL_IDX_W'(k))
				|| (clr_single && single_idx_ff == `PIL_IDX_W'(k));
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Level cells; the pair of flops encodes the three level states
	generate
		for (genvar k = 0; k < `PIL_N_LVL; k++)
		begin : g_cell
			pil_level_cell u_cell (
				.clk_sys               (clk_sys),
				.rstn                  (rstn),
				.start_clr             (console_start),
				.pulse                 (level_pulse[k]),
				.armed                 (armed[k] && present[k]),
				.set_svc               (set_svc[k]),
				.clr                   (clr[k]),
				.level_pending_flop    (pending[k]),
				.level_in_service_flop (in_svc[k])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Priority resolution in rank order
	generate
		for (genvar r = 0; r < `PIL_N_LVL; r++)
		begin : g_rank
			localparam logic [`PIL_IDX_W-1:0] F = rank_to_flat(`PIL_IDX_W'(r));
			// A disabled waiting level never becomes a candidate
			assign cand_rk[r] = pending[F] && enabled[F] && !in_svc[F];
			assign svc_rk[r]  = in_svc[F];
		end
	endgenerate

	// Best waiting candidate
	pil_prio_enc u_cand (
		.vec   (cand_rk),
		.found (cand_found),
		.rank  (cand_rank)
	);

	// Highest level now in service, the routine that is running
	pil_prio_enc u_act (
		.vec   (svc_rk),
		.found (act_found),
		.rank  (act_rank)
	);

	assign act_idx = rank_to_flat(act_rank);

	// Only a strictly higher level may interrupt the running routine
	assign cand_ok = cand_found && (!act_found || cand_rank < act_rank);

	////////////////////////////////////////////////////////////////
	// Interrupt request flop and sequencer handshake

	// Acknowledge is honoured only while a request stands
	assign take_ack = seq_cmd.ack && req_ff;

	// Request tracks the best candidate and drops on acknowledge
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || console_start)
		begin
			req_ff     <= 1'b0;
			req_idx_ff <= '0;
		end
		else
		begin
			req_ff     <= cand_ok && !take_ack;
			req_idx_ff <= rank_to_flat(cand_rank);
		end
	end

	// Level number is registered with the request and follows the best candidate every cycle
	assign seq_req.req   = req_ff;
	assign seq_req.level = flat_to_level(req_idx_ff);

	// Return branch clears the highest level now in service
	assign clr_branch = seq_cmd.ind_branch && act_found;

	// Single-instruction levels: remember which one was entered
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || console_start)
		begin
			single_ff     <= 1'b0;
			single_idx_ff <= '0;
		end
		else if (take_ack)
		begin
			single_ff     <= SINGLE_LVLS[req_idx_ff];
			single_idx_ff <= req_idx_ff;
		end
		else if (seq_cmd.inst_done)
			single_ff     <= 1'b0;
	end

	// One-cycle instructions leave the level active for software to clear
	assign clr_single = single_ff && seq_cmd.inst_done && seq_cmd.multi_cycle;

	// The program counter save is done by the sequencer, not stored here

	////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle for every access
	assign bus_rd          = avs_read && !bus_ack_ff;
	// A write lands only at the edge where waitrequest is seen low
	assign bus_wr          = avs_write && bus_ack_ff;
	assign avs_waitrequest = (avs_read || avs_write) && !bus_ack_ff;
	assign avs_readdata    = rdata_ff;

	// Ack pulses one cycle after a request is first seen
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			bus_ack_ff <= 1'b0;
		else
			bus_ack_ff <= (avs_read || avs_write) && !bus_ack_ff;
	end

	// Group select for the arm mask
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			group_ff <= 6'h00;
		else if (bus_wr && avs_address == `PIL_REG_GROUP && avs_byteenable[0])
			group_ff <= avs_writedata[5:0];
	end

	// Codes past the last group select nothing
	assign grp_valid = group_ff < 6'(`PIL_N_GRP);

	// Arm mask per group of sixteen, written through the group select
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			for (int g = 0; g < `PIL_N_GRP; g++)
				arm_ff[g] <= `PIL_ARM_RST;
		end
		else if (bus_wr && avs_address == `PIL_REG_ARM && grp_valid)
		begin
			for (int b = 0; b < 2; b++)
				if (avs_byteenable[b])
					arm_ff[group_ff][b*8 +: 8] <= avs_writedata[b*8 +: 8];
		end
	end

	// Pending and in-service view of the selected group
	always_comb
	begin
		grp_pend = '0;
		grp_svc  = '0;
		if (grp_valid)
		begin
			grp_pend = pending[`PIL_N_HW + int'(group_ff) * `PIL_GRP_W +: `PIL_GRP_W];
			grp_svc  = in_svc[`PIL_N_HW + int'(group_ff) * `PIL_GRP_W +: `PIL_GRP_W];
		end
	end

	// Read data is registered; unmapped offsets read zero
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			rdata_ff <= 32'h00000000;
		else if (bus_rd)
		begin
			rdata_ff <= 32'h00000000;
			case (avs_address)
				`PIL_REG_CTRL:
				begin
					rdata_ff[`PIL_CTRL_EN]  <= enable_ff;
					rdata_ff[`PIL_CTRL_IND] <= interrupt_enabled_ind;
				end
				`PIL_REG_GROUP:
					rdata_ff[5:0] <= group_ff;
				`PIL_REG_ARM:
					rdata_ff[15:0] <= grp_valid ? arm_ff[group_ff] : 16'h0000;
				`PIL_REG_LVLSTAT:
				begin
					rdata_ff[15:0]                        <= grp_pend;
					rdata_ff[`PIL_LS_SVC +: `PIL_GRP_W]   <= grp_svc;
				end
				`PIL_REG_STATUS:
				begin
					rdata_ff[`PIL_LVL_W-1:0]              <= seq_req.level;
					rdata_ff[`PIL_ST_REQ]                 <= req_ff;
					rdata_ff[`PIL_ST_ACT_LVL +: `PIL_LVL_W] <= flat_to_level(act_idx);
					rdata_ff[`PIL_ST_ACT]                 <= act_found;
				end
				default:
					rdata_ff <= 32'h00000000;
			endcase
		end
	end

endmodule : pil_top

// *** test/pil_seq_model.sv ***
// Purpose: Instruction sequencer on the far side of the interrupt levels
// Assumes: Bench raises take to let a standing request be acknowledged
// Notes:   slow makes the model see a request for that many cycles first
`timescale 1ns/1ps

module pil_seq_model
	import pil_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	// Bench commands
	input  wire logic                  take,
	input  wire logic                  ret,
	input  wire logic [1:0]            slow,
	// Block side
	input  wire pil_pkg::pil_seq_req_s seq_req,
	output pil_pkg::pil_seq_cmd_s      seq_cmd
);
	logic [1:0] gap_ff;
	logic [1:0] seen_ff;

	////////////////////////////////////////////////////////////////
	// Strobes; the gap keeps a second ack off the dropping request
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			seq_cmd <= '0;
			gap_ff  <= 2'h0;
			seen_ff <= 2'h0;
		end
		else
		begin
			seen_ff <= !seq_req.req ? 2'h0 : (seen_ff == 2'h3 ? 2'h3 : seen_ff + 2'h1);
			// Never two acks in a row: the request is already dropping
			seq_cmd.ack <= take && seq_req.req && gap_ff == 2'h0 && !seq_cmd.ack
				&& seen_ff >= slow;
			gap_ff <= seq_cmd.ack ? 2'h3 : (gap_ff != 2'h0 ? gap_ff - 2'h1 : 2'h0);
			seq_cmd.inst_done   <= seq_cmd.ack;
			seq_cmd.multi_cycle <= 1'b0;
			seq_cmd.ind_branch  <= ret;
		end
	end
endmodule : pil_seq_model

// *** test/pil_top_properties.sv ***
// Purpose: Port-level timing checks of the interrupt levels
// Assumes: Power-on level is level 036, flat index 6
// Notes:   svc_ff follows only the power-on level, which outranks all
`timescale 1ns/1ps
`include "pil_params.svh"

module pil_top_properties
	import pil_pkg::*;
(
	// Watched ports
	input wire logic                  clk_sys,
	input wire logic                  rstn,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic                  avs_waitrequest,
	input wire logic                  console_start,
	input wire logic                  enable_switch_held,
	input wire logic                  interrupt_enabled_ind,
	input wire logic [`PIL_N_LVL-1:0] level_pulse,
	input wire pil_pkg::pil_seq_cmd_s seq_cmd,
	input wire pil_pkg::pil_seq_req_s seq_req
);
	logic svc_ff;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////
	// Power-on level in service; any clear then hits it first
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || console_start)
			svc_ff <= 1'b0;
		else if (seq_cmd.ack && seq_req.req && seq_req.level == 10'h01E)
			svc_ff <= 1'b1;
		else if (seq_cmd.ind_branch)
			svc_ff <= 1'b0;
	end

	sequence pwr_kick_s;
		level_pulse[6] && !svc_ff && !console_start && !seq_cmd.ack
		##1 !console_start && !seq_cmd.ack;
	endsequence

	wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	idle_ready_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high while idle");
	pwr_req_a: assert property (pwr_kick_s |=> seq_req.req && seq_req.level == 10'h01E)
		else $error("power-on pulse gave no request");
	gate_off_a: assert property ($rose(seq_req.req) && !$past(interrupt_enabled_ind) |-> seq_req.level inside {10'h01E, 10'h01F})
		else $error("request rose while disabled");
	ack_drop_a: assert property (seq_cmd.ack && seq_req.req |=> !seq_req.req)
		else $error("request kept after acknowledge");
	start_clr_a: assert property (console_start && !avs_write |=> !seq_req.req && interrupt_enabled_ind == enable_switch_held)
		else $error("console start did not clear");
	switch_on_a: assert property (enable_switch_held |-> interrupt_enabled_ind)
		else $error("switch did not force indicator");
	block_lower_a: assert property (svc_ff && $past(svc_ff) |-> !seq_req.req)
		else $error("request under highest level in service");
	clear_svc_a: assert property (svc_ff && seq_cmd.ind_branch && !level_pulse[6] |=> (!(seq_req.req && seq_req.level == 10'h01E))[*2])
		else $error("cleared level requested again");

	c_special: cover property (seq_cmd.ack && seq_req.level == 10'h3FF);
	c_clear: cover property (svc_ff && seq_cmd.ind_branch);
	c_start: cover property (console_start && seq_req.req);
endmodule : pil_top_properties

bind pil_top pil_top_properties i_props (.clk_sys(clk_sys), .rstn(rstn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .console_start(console_start),
	.enable_switch_held(enable_switch_held), .interrupt_enabled_ind(interrupt_enabled_ind),
	.level_pulse(level_pulse), .seq_cmd(seq_cmd), .seq_req(seq_req));

// *** test/priority_interrupt_levels_bench.sv ***
// Purpose: Scenario bench of the interrupt levels
// Assumes: Every level fitted, no single-instruction levels
// Notes:   Flat index 1 is level 031, 8 is 040, 935 is 01777
`timescale 1ns/1ps
`include "pil_params.svh"

module priority_interrupt_levels_bench;
	import pil_pkg::*;
	localparam logic [`PIL_N_LVL-1:0] ONE = 1;
	logic                  clk_sys = 1'b0;
	logic                  rstn = 1'b0;
	logic [4:0]            avs_address = 5'h00;
	logic                  avs_read = 1'b0;
	logic                  avs_write = 1'b0;
	logic [31:0]           avs_writedata = 32'h0;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest;
	logic                  console_start = 1'b0;
	logic                  sw_held = 1'b0;
	logic                  ind;
	logic [`PIL_N_LVL-1:0] level_pulse = '0;
	pil_seq_cmd_s          seq_cmd;
	pil_seq_req_s          seq_req;
	logic                  take = 1'b0;
	logic                  ret = 1'b0;
	logic [1:0]            slow = 2'h0;
	logic [31:0]           d;
	int                    err_total = 0;
	int                    cmp_count = 0;

	// Clock of 100 ns
	always #50 clk_sys = ~clk_sys;

	pil_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.console_start(console_start), .enable_switch_held(sw_held),
		.interrupt_enabled_ind(ind), .level_pulse(level_pulse), .seq_cmd(seq_cmd),
		.seq_req(seq_req));
	pil_seq_model i_seq (.clk_sys(clk_sys), .rstn(rstn), .take(take), .ret(ret),
		.slow(slow), .seq_req(seq_req), .seq_cmd(seq_cmd));

	////////////////////////////////////////////////////////////////
	task finish_test;
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	task ck(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : ck

	task tmo(input string n);
		ck(n, 32'h1, 32'h0);
		finish_test();
	endtask : tmo

	// Avalon cycle; held until waitrequest is seen low at an edge
	task bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
		int n;
		avs_address   <= a;
		avs_writedata <= wd;
		avs_read      <= !w;
		avs_write     <= w;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0)
				break;
		end
		d = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
		if (n == 20)
			tmo("bus_answer");
	endtask : bus

	task pl(input logic [`PIL_N_LVL-1:0] m);
		level_pulse <= m;
		@(posedge clk_sys);
		level_pulse <= '0;
		@(posedge clk_sys);
	endtask : pl

	task wq(input logic [9:0] lv);
		int n;
		for (n = 0; n < 30; n++)
		begin
			@(posedge clk_sys);
			if (seq_req.req === 1'b1 && seq_req.level === lv)
				break;
		end
		if (n == 30)
			tmo("req_level");
		cmp_count++;
	endtask : wq

	task nr;
		repeat (4) @(posedge clk_sys);
		ck("req", 32'h0, 32'(seq_req.req));
	endtask : nr

	task ak;
		take <= 1'b1;
		repeat (6) @(posedge clk_sys);
		take <= 1'b0;
		@(posedge clk_sys);
	endtask : ak

	task rt;
		ret <= 1'b1;
		@(posedge clk_sys);
		ret <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : rt

	task stt(input logic any, input logic [9:0] lv);
		bus(1'b0, `PIL_REG_STATUS, 32'h0);
		ck("svc_any", 32'(any), 32'(d[21]));
		if (any)
			ck("svc_level", 32'(lv), 32'(d[20:11]));
	endtask : stt

	////////////////////////////////////////////////////////////////
	task t_reset;
		ck("req", 32'h0, 32'(seq_req.req));
		bus(1'b0, `PIL_REG_CTRL, 32'h0);
		ck("ctrl", 32'h0, d);
		bus(1'b1, 5'h1C, 32'hFFFFFFFF);
		bus(1'b0, 5'h14, 32'h0);
		ck("hole", 32'h0, d);
	endtask : t_reset

	// Nesting, with a slow acknowledge on the outer level
	task t_nest;
		bus(1'b1, `PIL_REG_CTRL, 32'h1);
		slow <= 2'h2;
		pl(ONE << 8);
		wq(10'h020);
		ak();
		slow <= 2'h0;
		pl(ONE << 1);
		wq(10'h019);
		ak();
		stt(1'b1, 10'h019);
		pl(ONE << 16);
		nr();
		rt();
		stt(1'b1, 10'h020);
		nr();
		rt();
		wq(10'h028);
		ak();
		rt();
		stt(1'b0, 10'h000);
	endtask : t_nest

	task t_gate;
		bus(1'b1, `PIL_REG_CTRL, 32'h0);
		pl(ONE << 1);
		nr();
		bus(1'b1, `PIL_REG_CTRL, 32'h1);
		nr();
		pl(ONE << 3);
		wq(10'h01B);
		bus(1'b1, `PIL_REG_CTRL, 32'h0);
		nr();
		bus(1'b1, `PIL_REG_CTRL, 32'h1);
		wq(10'h01B);
		ak();
		rt();
	endtask : t_gate

	task t_power;
		bus(1'b1, `PIL_REG_CTRL, 32'h0);
		pl(ONE << 1 | ONE << 6 | ONE << 7);
		wq(10'h01E);
		ak();
		nr();
		rt();
		wq(10'h01F);
		ak();
		rt();
		nr();
	endtask : t_power

	// Last group armed on one bit, then a group code out of range
	task t_special;
		bus(1'b1, `PIL_REG_GROUP, 32'h37);
		bus(1'b1, `PIL_REG_ARM, 32'h8000);
		bus(1'b0, `PIL_REG_ARM, 32'h0);
		ck("arm", 32'h8000, d);
		bus(1'b1, `PIL_REG_CTRL, 32'h1);
		pl(ONE << 934 | ONE << 935);
		wq(10'h3FF);
		bus(1'b0, `PIL_REG_LVLSTAT, 32'h0);
		ck("lvlstat", 32'h8000, d);
		ak();
		bus(1'b0, `PIL_REG_LVLSTAT, 32'h0);
		ck("lvlstat", 32'h80008000, d);
		rt();
		bus(1'b0, `PIL_REG_LVLSTAT, 32'h0);
		ck("lvlstat", 32'h0, d);
		bus(1'b1, `PIL_REG_GROUP, 32'h38);
		bus(1'b1, `PIL_REG_ARM, 32'hFFFF);
		bus(1'b0, `PIL_REG_ARM, 32'h0);
		ck("arm", 32'h0, d);
	endtask : t_special

	task t_console;
		pl(ONE << 1);
		wq(10'h019);
		console_start <= 1'b1;
		@(posedge clk_sys);
		console_start <= 1'b0;
		nr();
		bus(1'b0, `PIL_REG_CTRL, 32'h0);
		ck("ctrl", 32'h0, d);
		sw_held <= 1'b1;
		pl(ONE << 3);
		ck("ind", 32'h1, 32'(ind));
		wq(10'h01B);
		ak();
		rt();
		sw_held <= 1'b0;
		nr();
	endtask : t_console

	// Main sequence after a reset of six cycles
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_nest();
		t_gate();
		t_power();
		t_special();
		t_console();
		finish_test();
	end
endmodule : priority_interrupt_levels_bench
